// *** src/mso_defines.svh ***
`ifndef MSO_DEFINES_SVH
`define MSO_DEFINES_SVH

// register byte offsets on the bus
`define MSO_OFF_CMD 8'h00
`define MSO_OFF_OPERAND 8'h04
`define MSO_OFF_ACC 8'h08
`define MSO_OFF_FLAGS 8'h0C
`define MSO_OFF_PTR_LOW 8'h10
`define MSO_OFF_PTR_HIGH 8'h14
`define MSO_OFF_HIGH_LATCH 8'h18
`define MSO_OFF_STATUS 8'h1C
`define MSO_OFF_DADDR 8'h20
`define MSO_OFF_DDATA 8'h24

`define MSO_BYTE_RESET 8'h00
`define MSO_ZERO_BYTE 8'h00
`define MSO_ONE_BYTE 8'h01
`define MSO_BASE_ADDR_MASK 8'h7F

// decimal adjust
`define MSO_NIBBLE_MAX 4'h9
`define MSO_DAA_NONE 8'h00
`define MSO_DAA_LOW 8'h06
`define MSO_DAA_HIGH 8'h60
`define MSO_DAA_BOTH 8'h66

// instruction cycles
`define MSO_CYC_BASE 4'h1
`define MSO_CYC_EXT 4'h2
`define MSO_CYC_TABLE 4'h2
`define MSO_CYC_SKIP 4'h1

`endif

// *** src/mso_pkg.sv ***
package mso_pkg;

  typedef enum logic [4:0] {
    op_nop,
    op_skip_zero_with_move,
    op_skip_when_zero_bit,
    op_table_read_paged,
    op_table_read_last_page,
    op_incr_table_read_paged,
    op_incr_table_read_last_page,
    op_xor_to_acc,
    op_exclusive_or_to_memory,
    op_xor_imm_to_acc,
    op_ext_add_carry_to_acc,
    op_ext_add_carry_to_mem,
    op_ext_sum_to_acc,
    op_ext_sum_to_mem,
    op_ext_conjunction_to_acc,
    op_ext_conjunction_to_mem,
    op_ext_zero_fill,
    op_ext_zero_fill_bit,
    op_ext_invert_mem,
    op_ext_invert_to_acc,
    op_ext_decimal_adjust,
    op_ext_decrement_mem,
    op_ext_decrement_to_acc,
    op_ext_increment_mem,
    op_ext_increment_to_acc,
    op_ext_move_to_acc,
    op_ext_move_to_mem,
    op_ext_disjunction_to_acc,
    op_ext_disjunction_to_mem,
    op_ext_rotate_left,
    op_ext_skip_zero_with_move,
    op_ext_skip_when_zero_bit
  } mso_op_t;

  typedef struct packed {
    logic signed_result_flag;
    logic arith_sign_wrap_flag;
    logic z;
    logic half_carry_flag;
    logic c;
  } mso_flags_t;

  typedef struct packed {
    logic [2:0] bit_sel;
    mso_op_t op;
  } mso_cmd_t;

  typedef struct packed {
    logic [7:0] imm;
    logic [7:0] addr;
  } mso_operand_t;

  typedef enum logic [2:0] {
    st_idle,
    st_read,
    st_exec,
    st_pm,
    st_table,
    st_hold
  } mso_state_t;

endpackage : mso_pkg

// *** src/mso_data_ram.sv ***
`timescale 1ns/100ps
module mso_data_ram #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // array has no reset; contents are undefined until written
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= mem[addr];
    end
  end
endmodule : mso_data_ram

// *** src/mso_alu_core.sv ***
`timescale 1ns/100ps
`include "mso_defines.svh"
// Operation
// - skip-zero-with-move loads memory byte into acc, skips when byte is zero
// - bit-test skip skips when selected memory bit is zero, no flags
// - a skipping base skip takes two instruction cycles
// - paged table read uses high and low pointer; low to memory, high latched
// - last-page table read addresses last page with low pointer only
// - incrementing paged table read bumps low pointer before the read
// - incrementing last-page table read bumps low pointer before the read
// - xor with memory or immediate to acc or memory, zero flag only
// - extended instructions reach every data memory section directly
// - add with carry to acc or memory, updates ov z ac c sc
// - add without carry to acc or memory, updates ov z ac c sc
// - and with memory to acc or memory, zero flag only
// - clear writes zero byte or zero bit, no flags
// - complement memory to memory or acc, zero flag updated
// - decimal adjust adds six per nibble above nine or with its carry flag, ac for low and c for high
// - correction is 00h 06h 60h or 66h, result to memory
// - decimal adjust touches only carry, set for sums beyond two digits
// - decrement memory to memory or acc, zero flag updated
// - increment memory to memory or acc, zero flag updated
// - move memory to acc or acc to memory, no flags
// - or with memory to acc or memory, zero flag only
// - rotate memory left, bit seven into bit zero, no flags
// - a skipping extended skip takes three instruction cycles
module mso_alu_core #(
  parameter int PM_AW = 12,
  parameter int INSTR_CLKS = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic pm_rd_en,
  output logic [PM_AW-1:0] pm_addr,
  input wire logic [15:0] pm_rdata,
  output logic busy,
  output logic instr_done,
  output logic skip_next
);
  function automatic logic is_ext(input mso_pkg::mso_op_t op);
    return op >= mso_pkg::op_ext_add_carry_to_acc;
  endfunction : is_ext

  function automatic logic is_table(input mso_pkg::mso_op_t op);
    return op inside {mso_pkg::op_table_read_paged, mso_pkg::op_table_read_last_page,
                      mso_pkg::op_incr_table_read_paged, mso_pkg::op_incr_table_read_last_page};
  endfunction : is_table

  // bus slave: zero wait state, always OKAY
  logic ap_valid;
  logic dp_wr;
  logic [7:0] dp_addr;
  logic next_dp_wr;
  logic [7:0] next_dp_addr;
  logic [31:0] next_hrdata;

  // core state
  mso_pkg::mso_state_t state, next_state;
  mso_pkg::mso_cmd_t cmd, next_cmd;
  mso_pkg::mso_operand_t operand, next_operand;
  mso_pkg::mso_flags_t flags, next_flags;
  logic [7:0] acc, next_acc;
  logic [7:0] table_pointer_low_byte, next_table_pointer_low_byte;
  logic [7:0] table_pointer_high_byte, next_table_pointer_high_byte;
  logic [7:0] table_read_high_latch, next_table_read_high_latch;
  logic [7:0] daddr, next_daddr;
  logic [7:0] ddata, next_ddata;
  logic dread_pend, next_dread_pend;
  logic [7:0] cnt, next_cnt;
  logic [3:0] cyc_total, next_cyc_total;
  logic skip_flag, next_skip_flag;
  logic next_pm_rd_en;
  logic [PM_AW-1:0] next_pm_addr;

  // memory port
  logic ram_we;
  logic [7:0] ram_addr;
  logic [7:0] ram_wdata;
  logic [7:0] ram_q;

  // alu outputs
  logic [7:0] res;
  mso_pkg::mso_flags_t res_flags;
  logic res_to_acc;
  logic res_to_mem;
  logic res_skip;
  logic [8:0] sum9;
  logic [4:0] half5;
  logic cin;
  logic [7:0] corr;
  logic [7:0] eff_addr;
  logic [7:0] bumped_pointer;
  logic sw_ok;
  logic last_clk;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign ap_valid = hsel & htrans[1] & hready;
  assign busy = (state != mso_pkg::st_idle);
  assign sw_ok = dp_wr & ~busy;
  assign last_clk = (cnt == 8'((32'(cyc_total) * INSTR_CLKS) - 1));
  assign instr_done = (state == mso_pkg::st_hold) & last_clk;
  assign skip_next = instr_done & skip_flag;
  // base forms see one section only; extended forms take the full address
  assign eff_addr = is_ext(cmd.op) ? operand.addr : (operand.addr & `MSO_BASE_ADDR_MASK);

  always_comb begin
    next_dp_wr = ap_valid & hwrite;
    next_dp_addr = ap_valid ? haddr[7:0] : dp_addr;
    next_hrdata = hrdata;
    if (ap_valid && !hwrite) begin
      unique case (haddr[7:0])
        `MSO_OFF_CMD: next_hrdata = {24'h000000, cmd};
        `MSO_OFF_OPERAND: next_hrdata = {16'h0000, operand};
        `MSO_OFF_ACC: next_hrdata = {24'h000000, acc};
        `MSO_OFF_FLAGS: next_hrdata = {27'h0000000, flags};
        `MSO_OFF_PTR_LOW: next_hrdata = {24'h000000, table_pointer_low_byte};
        `MSO_OFF_PTR_HIGH: next_hrdata = {24'h000000, table_pointer_high_byte};
        `MSO_OFF_HIGH_LATCH: next_hrdata = {24'h000000, table_read_high_latch};
        `MSO_OFF_STATUS: next_hrdata = {20'h00000, cyc_total, 6'h00, skip_flag, busy};
        `MSO_OFF_DADDR: next_hrdata = {24'h000000, daddr};
        `MSO_OFF_DDATA: next_hrdata = {24'h000000, ddata};
        default: next_hrdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr <= 1'b0;
      dp_addr <= `MSO_BYTE_RESET;
      hrdata <= 32'h00000000;
    end else begin
      dp_wr <= next_dp_wr;
      dp_addr <= next_dp_addr;
      hrdata <= next_hrdata;
    end
  end

  always_comb begin
    res = ram_q;
    res_flags = flags;
    res_to_acc = 1'b0;
    res_to_mem = 1'b0;
    res_skip = 1'b0;
    cin = (cmd.op inside {mso_pkg::op_ext_add_carry_to_acc, mso_pkg::op_ext_add_carry_to_mem}) & flags.c;
    sum9 = {1'b0, acc} + {1'b0, ram_q} + {8'h00, cin};
    half5 = {1'b0, acc[3:0]} + {1'b0, ram_q[3:0]} + {4'h0, cin};
    corr = `MSO_DAA_NONE;
    unique case (cmd.op)
      mso_pkg::op_skip_zero_with_move, mso_pkg::op_ext_skip_zero_with_move: begin
        res_to_acc = 1'b1;
        res_skip = (ram_q == `MSO_ZERO_BYTE);
      end
      mso_pkg::op_skip_when_zero_bit, mso_pkg::op_ext_skip_when_zero_bit: begin
        res_skip = ~ram_q[cmd.bit_sel];
      end
      mso_pkg::op_xor_to_acc, mso_pkg::op_exclusive_or_to_memory, mso_pkg::op_xor_imm_to_acc: begin
        res = acc ^ ((cmd.op == mso_pkg::op_xor_imm_to_acc) ? operand.imm : ram_q);
        res_to_mem = (cmd.op == mso_pkg::op_exclusive_or_to_memory);
        res_to_acc = ~res_to_mem;
        res_flags.z = (res == `MSO_ZERO_BYTE);
      end
      mso_pkg::op_ext_add_carry_to_acc, mso_pkg::op_ext_add_carry_to_mem,
      mso_pkg::op_ext_sum_to_acc, mso_pkg::op_ext_sum_to_mem: begin
        res = sum9[7:0];
        res_to_mem = (cmd.op inside {mso_pkg::op_ext_add_carry_to_mem, mso_pkg::op_ext_sum_to_mem});
        res_to_acc = ~res_to_mem;
        res_flags.c = sum9[8];
        res_flags.half_carry_flag = half5[4];
        res_flags.z = (sum9[7:0] == `MSO_ZERO_BYTE);
        res_flags.arith_sign_wrap_flag = (acc[7] == ram_q[7]) && (sum9[7] != acc[7]);
        res_flags.signed_result_flag = res_flags.arith_sign_wrap_flag ^ sum9[7];
      end
      mso_pkg::op_ext_conjunction_to_acc, mso_pkg::op_ext_conjunction_to_mem: begin
        res = acc & ram_q;
        res_to_mem = (cmd.op == mso_pkg::op_ext_conjunction_to_mem);
        res_to_acc = ~res_to_mem;
        res_flags.z = (res == `MSO_ZERO_BYTE);
      end
      mso_pkg::op_ext_zero_fill: begin
        res = `MSO_ZERO_BYTE;
        res_to_mem = 1'b1;
      end
      mso_pkg::op_ext_zero_fill_bit: begin
        res[cmd.bit_sel] = 1'b0;
        res_to_mem = 1'b1;
      end
      mso_pkg::op_ext_invert_mem, mso_pkg::op_ext_invert_to_acc: begin
        res = ~ram_q;
        res_to_acc = (cmd.op == mso_pkg::op_ext_invert_to_acc);
        res_to_mem = ~res_to_acc;
        res_flags.z = (res == `MSO_ZERO_BYTE);
      end
      mso_pkg::op_ext_decimal_adjust: begin
        // nibbles judged on the unadjusted acc, as the four-constant form implies
        unique case ({(acc[7:4]>`MSO_NIBBLE_MAX)|flags.c, (acc[3:0]>`MSO_NIBBLE_MAX)|flags.half_carry_flag})
          2'b00: corr = `MSO_DAA_NONE;
          2'b01: corr = `MSO_DAA_LOW;
          2'b10: corr = `MSO_DAA_HIGH;
          2'b11: corr = `MSO_DAA_BOTH;
        endcase
        res = acc + corr;
        res_to_mem = 1'b1;
        res_flags.c = corr[6] | ({1'b0, acc} + {1'b0, corr} > 9'h0FF);
      end
      mso_pkg::op_ext_decrement_mem, mso_pkg::op_ext_decrement_to_acc: begin
        res = ram_q - `MSO_ONE_BYTE;
        res_to_acc = (cmd.op == mso_pkg::op_ext_decrement_to_acc);
        res_to_mem = ~res_to_acc;
        res_flags.z = (res == `MSO_ZERO_BYTE);
      end
      mso_pkg::op_ext_increment_mem, mso_pkg::op_ext_increment_to_acc: begin
        res = ram_q + `MSO_ONE_BYTE;
        res_to_acc = (cmd.op == mso_pkg::op_ext_increment_to_acc);
        res_to_mem = ~res_to_acc;
        res_flags.z = (res == `MSO_ZERO_BYTE);
      end
      mso_pkg::op_ext_move_to_acc: res_to_acc = 1'b1;
      mso_pkg::op_ext_move_to_mem: begin
        res = acc;
        res_to_mem = 1'b1;
      end
      mso_pkg::op_ext_disjunction_to_acc, mso_pkg::op_ext_disjunction_to_mem: begin
        res = acc | ram_q;
        res_to_mem = (cmd.op == mso_pkg::op_ext_disjunction_to_mem);
        res_to_acc = ~res_to_mem;
        res_flags.z = (res == `MSO_ZERO_BYTE);
      end
      mso_pkg::op_ext_rotate_left: begin
        res = {ram_q[6:0], ram_q[7]};
        res_to_mem = 1'b1;
      end
      mso_pkg::op_nop, mso_pkg::op_table_read_paged, mso_pkg::op_table_read_last_page,
      mso_pkg::op_incr_table_read_paged, mso_pkg::op_incr_table_read_last_page: begin
        res = ram_q;
      end
    endcase
  end

  // pointer bump comes before the address is formed
  assign bumped_pointer = (cmd.op inside {mso_pkg::op_incr_table_read_paged, mso_pkg::op_incr_table_read_last_page})
                          ? table_pointer_low_byte + `MSO_ONE_BYTE : table_pointer_low_byte;

  always_comb begin
    next_state = state;
    next_cmd = cmd;
    next_operand = operand;
    next_flags = flags;
    next_acc = acc;
    next_table_pointer_low_byte = table_pointer_low_byte;
    next_table_pointer_high_byte = table_pointer_high_byte;
    next_table_read_high_latch = table_read_high_latch;
    next_daddr = daddr;
    next_ddata = dread_pend ? ram_q : ddata;
    next_dread_pend = 1'b0;
    next_cnt = busy ? cnt + 8'h01 : 8'h00;
    next_cyc_total = cyc_total;
    next_skip_flag = skip_flag;
    next_pm_rd_en = 1'b0;
    next_pm_addr = pm_addr;
    ram_we = 1'b0;
    ram_addr = daddr;
    ram_wdata = ddata;
    // software writes are dropped while an instruction runs
    if (sw_ok) begin
      unique case (dp_addr)
        `MSO_OFF_CMD: begin
          next_cmd = mso_pkg::mso_cmd_t'(hwdata[7:0]);
          next_state = mso_pkg::st_read;
        end
        `MSO_OFF_OPERAND: next_operand = mso_pkg::mso_operand_t'(hwdata[15:0]);
        `MSO_OFF_ACC: next_acc = hwdata[7:0];
        `MSO_OFF_FLAGS: next_flags = mso_pkg::mso_flags_t'(hwdata[4:0]);
        `MSO_OFF_PTR_LOW: next_table_pointer_low_byte = hwdata[7:0];
        `MSO_OFF_PTR_HIGH: next_table_pointer_high_byte = hwdata[7:0];
        `MSO_OFF_DADDR: begin
          next_daddr = hwdata[7:0];
          ram_addr = hwdata[7:0];
          next_dread_pend = 1'b1;
        end
        `MSO_OFF_DDATA: begin
          ram_we = 1'b1;
          ram_wdata = hwdata[7:0];
          next_ddata = hwdata[7:0];
        end
        default: next_state = state;
      endcase
    end
    unique case (state)
      mso_pkg::st_idle: next_cnt = 8'h00;
      mso_pkg::st_read: begin
        ram_addr = eff_addr;
        next_state = mso_pkg::st_exec;
      end
      mso_pkg::st_exec: begin
        ram_addr = eff_addr;
        next_skip_flag = res_skip;
        next_cyc_total = (is_table(cmd.op) ? `MSO_CYC_TABLE : (is_ext(cmd.op) ? `MSO_CYC_EXT : `MSO_CYC_BASE))
                         + (res_skip ? `MSO_CYC_SKIP : 4'h0);
        if (is_table(cmd.op)) begin
          next_table_pointer_low_byte = bumped_pointer;
          next_pm_rd_en = 1'b1;
          if (cmd.op inside {mso_pkg::op_table_read_paged, mso_pkg::op_incr_table_read_paged}) begin
            next_pm_addr = PM_AW'({table_pointer_high_byte, bumped_pointer});
          end else begin
            next_pm_addr = {{(PM_AW-8){1'b1}}, bumped_pointer};
          end
          next_state = mso_pkg::st_pm;
        end else begin
          ram_we = res_to_mem;
          ram_wdata = res;
          if (res_to_acc) begin
            next_acc = res;
          end
          next_flags = res_flags;
          next_state = mso_pkg::st_hold;
        end
      end
      mso_pkg::st_pm: next_state = mso_pkg::st_table;
      mso_pkg::st_table: begin
        ram_addr = eff_addr;
        ram_we = 1'b1;
        ram_wdata = pm_rdata[7:0];
        next_table_read_high_latch = pm_rdata[15:8];
        next_state = mso_pkg::st_hold;
      end
      mso_pkg::st_hold: begin
        if (last_clk) begin
          next_state = mso_pkg::st_idle;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= mso_pkg::st_idle;
      cmd <= '0;
      operand <= '0;
      flags <= '0;
      acc <= `MSO_BYTE_RESET;
      table_pointer_low_byte <= `MSO_BYTE_RESET;
      table_pointer_high_byte <= `MSO_BYTE_RESET;
      table_read_high_latch <= `MSO_BYTE_RESET;
      daddr <= `MSO_BYTE_RESET;
      ddata <= `MSO_BYTE_RESET;
      dread_pend <= 1'b0;
      cnt <= 8'h00;
      cyc_total <= 4'h0;
      skip_flag <= 1'b0;
      pm_rd_en <= 1'b0;
      pm_addr <= '0;
    end else begin
      state <= next_state;
      cmd <= next_cmd;
      operand <= next_operand;
      flags <= next_flags;
      acc <= next_acc;
      table_pointer_low_byte <= next_table_pointer_low_byte;
      table_pointer_high_byte <= next_table_pointer_high_byte;
      table_read_high_latch <= next_table_read_high_latch;
      daddr <= next_daddr;
      ddata <= next_ddata;
      dread_pend <= next_dread_pend;
      cnt <= next_cnt;
      cyc_total <= next_cyc_total;
      skip_flag <= next_skip_flag;
      pm_rd_en <= next_pm_rd_en;
      pm_addr <= next_pm_addr;
    end
  end

  mso_data_ram #(
    .AW(8),
    .DW(8)
  ) u_ram (
    .clk(hclk),
    .rst_n(hresetn),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(ram_wdata),
    .rdata(ram_q)
  );

  default clocking dcb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic in_exec;
  assign in_exec = (state == mso_pkg::st_exec);

  chk_skip_move: assert property (in_exec && cmd.op == mso_pkg::op_skip_zero_with_move
    |=> acc == $past(ram_q) && skip_flag == ($past(ram_q) == 8'h00) && flags == $past(flags))
    else $error("skip with move wrong");
  chk_skip_bit: assert property (in_exec && cmd.op == mso_pkg::op_skip_when_zero_bit
    |=> skip_flag == !$past(ram_q[cmd.bit_sel]) && flags == $past(flags))
    else $error("bit skip wrong");
  chk_base_skip_len: assert property (instr_done && skip_flag && !is_ext(cmd.op)
    |-> cyc_total == 4'h2 && cnt == 8'(2 * INSTR_CLKS - 1))
    else $error("base skip length wrong");
  chk_ext_skip_len: assert property (instr_done && skip_flag && is_ext(cmd.op)
    |-> cyc_total == 4'h3 && cnt == 8'(3 * INSTR_CLKS - 1))
    else $error("extended skip length wrong");
  chk_table_paged: assert property (pm_rd_en && cmd.op == mso_pkg::op_table_read_paged
    |-> pm_addr == PM_AW'({table_pointer_high_byte, table_pointer_low_byte})
    ##2 table_read_high_latch == $past(pm_rdata[15:8]))
    else $error("paged table read wrong");
  chk_table_last: assert property (pm_rd_en && cmd.op == mso_pkg::op_table_read_last_page
    |-> pm_addr == {{(PM_AW-8){1'b1}}, table_pointer_low_byte})
    else $error("last page address wrong");
  chk_table_incr: assert property (in_exec && cmd.op inside {mso_pkg::op_incr_table_read_paged,
    mso_pkg::op_incr_table_read_last_page} |=> table_pointer_low_byte == $past(table_pointer_low_byte) + 8'h01
    && pm_rd_en && pm_addr[7:0] == table_pointer_low_byte)
    else $error("pointer not bumped first");
  chk_xor_flags: assert property (in_exec && cmd.op == mso_pkg::op_xor_to_acc
    |=> acc == ($past(acc) ^ $past(ram_q)) && (flags & 5'h1B) == ($past(flags) & 5'h1B) &&
        flags.z == (acc == 8'h00))
    else $error("xor result or flags wrong");
  chk_add_sum: assert property (in_exec && cmd.op == mso_pkg::op_ext_sum_to_acc
    |=> {flags.c, acc} == {1'b0, $past(acc)} + {1'b0, $past(ram_q)})
    else $error("add result wrong");
  chk_clear_byte: assert property (in_exec && cmd.op == mso_pkg::op_ext_zero_fill
    |-> ram_we && ram_wdata == 8'h00 ##1 flags == $past(flags))
    else $error("clear wrong");
  chk_daa_flags: assert property (in_exec && cmd.op == mso_pkg::op_ext_decimal_adjust
    |=> (flags & 5'h1E) == ($past(flags) & 5'h1E))
    else $error("decimal adjust touched a flag");
  chk_rotate: assert property (in_exec && cmd.op == mso_pkg::op_ext_rotate_left
    |-> ram_we && ram_wdata == {ram_q[6:0], ram_q[7]} ##1 flags == $past(flags))
    else $error("rotate wrong");

  cov_base_skip: cover property (instr_done && skip_flag && !is_ext(cmd.op));
  cov_ext_skip: cover property (instr_done && skip_flag && is_ext(cmd.op));
  cov_table_read: cover property (state == mso_pkg::st_table);
  cov_daa_both: cover property (in_exec && cmd.op == mso_pkg::op_ext_decimal_adjust && corr == 8'h66);
endmodule : mso_alu_core

// *** verif/mso_pm_model.sv ***
`timescale 1ns/100ps
module mso_pm_model (
  input wire logic hclk,
  input wire logic pm_rd_en,
  input wire logic [11:0] pm_addr,
  output logic [15:0] pm_rdata
);
  // sync rom, one cycle late; toggles between reads so a stale word never looks valid
  always_ff @(posedge hclk) begin
    if (pm_rd_en) begin
      pm_rdata <= {pm_addr[3:0], pm_addr} ^ 16'hA55A;
    end else begin
      pm_rdata <= ~pm_rdata;
    end
  end
endmodule : mso_pm_model

// *** verif/mcu_alu_skip_table_ops_tb.sv ***
`timescale 1ns/100ps
module mcu_alu_skip_table_ops_tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, pm_rd_en, busy, instr_done, skip_next;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [11:0] pm_addr;
  logic [15:0] pm_rdata;
  logic [31:0] seed = 32'h56;
  int miscompares, checks_done, bcnt, dn, sk;
  mso_alu_core #(.PM_AW(12), .INSTR_CLKS(4)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pm_rd_en(pm_rd_en), .pm_addr(pm_addr),
    .pm_rdata(pm_rdata), .busy(busy), .instr_done(instr_done), .skip_next(skip_next));
  mso_pm_model pm (.hclk(hclk), .pm_rd_en(pm_rd_en), .pm_addr(pm_addr), .pm_rdata(pm_rdata));
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (busy === 1'b1) bcnt++;
    if (instr_done === 1'b1) begin
      dn++;
      sk = skip_next;
    end
  end
  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed & 32'h7FFF_FFFF;
  endfunction : rnd
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, s);
    end
  endtask : chk
  task tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  task waitrdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      miscompares++;
      tally_and_finish();
    end
  endtask : waitrdy
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsel <= 1'b1;
    waitrdy();
    htrans <= 2'b00;
    hwdata <= d;
    waitrdy();
    rd = hrdata;
  endtask : bus
  task run_one(input int op);
    int a, m, ad, f, p, hp, imm, bs, x, s, h, cyc, w, c, pa, r, ov, av, mv, fv, zr, n;
    a = rnd() & 255; m = rnd() & 255; f = rnd() & 31; p = rnd() & 255; hp = rnd() & 255;
    imm = rnd() & 255; bs = rnd() & 7; x = rnd() & 255;
    if (rnd() % 4 == 0) x = 0;
    // base forms only reach the low section
    ad = (op < 10) ? (m & 127) : m;
    bus(8'h20, 1, ad); bus(8'h24, 1, x); bus(8'h08, 1, a); bus(8'h0C, 1, f);
    bus(8'h10, 1, p); bus(8'h14, 1, hp); bus(8'h04, 1, (imm << 8) | m);
    bus(8'h18, 0, 0);
    h = rd;
    bcnt = 0; dn = 0; sk = 0;
    bus(8'h00, 1, (bs << 5) | op);
    bus(8'h08, 1, 32'h77);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (busy !== 1'b0 && n < 200);
    if (busy !== 1'b0) begin
      miscompares++;
      tally_and_finish();
    end
    s = 0; av = a; mv = x; fv = f;
    cyc = (op > 2 && op < 7) || op > 9 ? 2 : 1;
    case (op)
      1, 30: begin av = x; s = (x == 0); end
      2, 31: s = ((x >> bs) & 1) == 0;
      3, 4, 5, 6: begin
        if (op > 4) p = (p + 1) & 255;
        pa = (op % 2) ? ((hp << 8) | p) & 4095 : 3840 | p;
        w = (((pa & 15) << 12) | pa) ^ 'hA55A;
        mv = w & 255;
        h = w >> 8;
      end
      7: av = a ^ x;
      8: mv = a ^ x;
      9: av = a ^ imm;
      10, 11, 12, 13: begin
        c = (op < 12) ? (f & 1) : 0;
        r = a + x + c;
        ov = ((a ^ x) & 128) == 0 && ((a ^ r) & 128) != 0;
        fv = (r > 255) | ((((a & 15) + (x & 15) + c) > 15) << 1) | (ov << 3) | ((ov ^ ((r >> 7) & 1)) << 4);
        if (op % 2) mv = r & 255; else av = r & 255;
      end
      14: av = a & x;
      15: mv = a & x;
      16: mv = 0;
      17: mv = x & ~(1 << bs);
      18: mv = ~x & 255;
      19: av = ~x & 255;
      20: begin
        c = ((a & 15) > 9 || (f & 2)) ? 6 : 0;
        if ((a >> 4) > 9 || (f & 1)) c += 96;
        mv = (a + c) & 255;
        fv = (f & 30) | (c >= 96 || a + c > 255);
      end
      21: mv = (x - 1) & 255;
      22: av = (x - 1) & 255;
      23: mv = (x + 1) & 255;
      24: av = (x + 1) & 255;
      25: av = x;
      26: mv = a;
      27: av = a | x;
      28: mv = a | x;
      29: mv = ((x << 1) | (x >> 7)) & 255;
      default: ;
    endcase
    zr = (op inside {7, 9, 10, 12, 14, 19, 22, 24, 27}) ? av : mv;
    if (op inside {[7:15], 18, 19, [21:24], 27, 28}) fv = (fv & 27) | ((zr == 0) << 2);
    cyc += s;
    chk("busy_cycles", bcnt, cyc * 4);
    chk("done_pulses", dn, 1);
    chk("skip", sk, s);
    bus(8'h1C, 0, 0); chk("status", rd & 'hF02, (cyc << 8) | (s << 1));
    bus(8'h08, 0, 0); chk("acc", rd, av);
    bus(8'h0C, 0, 0); chk("flags", rd, fv);
    bus(8'h10, 0, 0); chk("tbl_ptr", rd, p);
    bus(8'h18, 0, 0); chk("tbl_latch", rd, h);
    bus(8'h20, 1, ad); bus(8'h24, 0, 0); chk("mem", rd, mv);
  endtask : run_one
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0;
    miscompares = 0; checks_done = 0; bcnt = 0; dn = 0; sk = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    bus(8'h08, 0, 0); chk("acc_reset", rd, 32'h0);
    bus(8'h3C, 0, 0); chk("unmapped", rd, 32'h0);
    for (int i = 0; i < 200; i++) run_one(i % 32);
    tally_and_finish();
  end
endmodule : mcu_alu_skip_table_ops_tb
